// >>> gpei_port.sv
`timescale 1ns/1ps

//------------------------------------------------------------------------------
// Eight-pin I/O port with grouped external interrupts
//------------------------------------------------------------------------------
module gpei_port
   import gpei_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // Register port
   input  wire logic [GPEI_AW-1:0]   reg_addr,
   input  wire logic [GPEI_DW-1:0]   reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [GPEI_DW-1:0]   reg_rdata,
   // Pads
   input  wire logic [GPEI_NPIN-1:0] pin_in,
   output logic      [GPEI_NPIN-1:0] pin_out,
   output logic      [GPEI_NPIN-1:0] pin_oe_n,
   output logic      [GPEI_NPIN-1:0] pin_pullup_en,
   // On-chip peripherals
   input  wire logic [GPEI_NPIN-1:0] alt_out_en,
   input  wire logic [GPEI_NPIN-1:0] alt_out_val,
   input  wire logic [GPEI_NPIN-1:0] alt_out_od,
   output logic      [GPEI_NPIN-1:0] alt_in_val,
   // Interrupt controller side
   input  wire logic                 cpu_irq_mask,
   input  wire logic [GPEI_NGRP-1:0] vector_fetch,
   output logic      [GPEI_NGRP-1:0] ext_irq_req,
   output logic                      ext_wake
);

   //---------------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------------
   logic [GPEI_NPIN-1:0] pin_data_latch_ff;
   logic [GPEI_NPIN-1:0] dir_ff;
   logic [GPEI_NPIN-1:0] opt_ff;
   logic [3:0]           ext_irq_sensitivity_ctrl_ff;
   logic [GPEI_NGRP-1:0] pend_ff;
   logic [GPEI_NGRP-1:0] nxt_pend;
   logic [GPEI_DW-1:0]   reg_rdata_ff;
   logic [GPEI_DW-1:0]   nxt_rdata;
   logic [GPEI_NPIN-1:0] pin_out_ff;
   logic [GPEI_NPIN-1:0] pin_oe_n_ff;
   logic [GPEI_NPIN-1:0] pin_pullup_ff;
   logic [GPEI_NPIN-1:0] alt_in_ff;
   logic [GPEI_NPIN-1:0] nxt_out;
   logic [GPEI_NPIN-1:0] nxt_oe_n;
   logic [GPEI_NPIN-1:0] nxt_pullup;
   logic [GPEI_NPIN-1:0] nxt_alt_in;
   logic [GPEI_NPIN-1:0] pin_lvl;
   logic [GPEI_NPIN-1:0] pin_prev;
   logic [GPEI_NPIN-1:0] pin_rise;
   logic [GPEI_NPIN-1:0] pin_fall;
   logic [GPEI_NPIN-1:0] irq_en;
   logic [GPEI_NPIN-1:0] data_view;
   logic [GPEI_NGRP-1:0] grp_evt;
   logic [GPEI_NGRP-1:0] grp_wake;
   logic                 wr_data;
   logic                 wr_dir;
   logic                 wr_opt;
   logic                 wr_sens;

   //---------------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------------
   // Qualify one pin against a group sensitivity code
   function automatic logic qualify(
      input logic [1:0] sens,
      input logic       lvl,
      input logic       rise,
      input logic       fall
   );
      logic hit;
      hit = 1'b0;
      case (sens)
         GPEI_SENS_FALL_LOW: hit = ~lvl;
         GPEI_SENS_RISE:     hit = rise;
         GPEI_SENS_FALL:     hit = fall;
         GPEI_SENS_BOTH:     hit = rise | fall;
         default:            hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Interrupt-capable pin kind
   function automatic logic kind_has_irq(input logic [2:0] kind);
      return (kind == GPEI_KIND_IRQ_PU) || (kind == GPEI_KIND_IRQ_FL);
   endfunction

   //---------------------------------------------------------------------------
   // Pin synchroniser
   //---------------------------------------------------------------------------
   gpei_pin_sync u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin_raw  (pin_in),
      .pin_lvl  (pin_lvl),
      .pin_prev (pin_prev),
      .pin_rise (pin_rise),
      .pin_fall (pin_fall)
   );

   //---------------------------------------------------------------------------
   // Register writes
   //---------------------------------------------------------------------------
   // Address decode for write strobes
   assign wr_data = reg_wr && (reg_addr == GPEI_OFS_DATA);
   assign wr_dir  = reg_wr && (reg_addr == GPEI_OFS_DIR);
   assign wr_opt  = reg_wr && (reg_addr == GPEI_OFS_OPT);
   assign wr_sens = reg_wr && (reg_addr == GPEI_OFS_SENS);

   // Data latch is written in any mode; the pin follows only in output
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_data_latch_ff <= GPEI_RST_DATA;
      end else if (wr_data) begin
         pin_data_latch_ff <= reg_wdata;
      end
   end

   // Direction register, bit n for pin n
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dir_ff <= GPEI_RST_DIR;
      end else if (wr_dir) begin
         dir_ff <= reg_wdata;
      end
   end

   // Option register, bit n for pin n
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         opt_ff <= GPEI_RST_OPT;
      end else if (wr_opt) begin
         opt_ff <= reg_wdata;
      end
   end

   // Sensitivity register, two bits per vector group
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_sensitivity_ctrl_ff <= GPEI_RST_SENS;
      end else if (wr_sens) begin
         ext_irq_sensitivity_ctrl_ff <= reg_wdata[3:0];
      end
   end

   //---------------------------------------------------------------------------
   // Register reads
   //---------------------------------------------------------------------------
   // Data address view per pin; pad levels come through the two-stage synchroniser
   always_comb begin
      data_view = pin_data_latch_ff;
      for (int i = 0; i < GPEI_NPIN; i++) begin
         if (GPEI_PIN_KIND[i] == GPEI_KIND_CAN_TX) begin
            data_view[i] = pin_lvl[i];                  // Always reads the pad level
         end else if (!dir_ff[i] && alt_out_en[i]) begin
            data_view[i] = alt_out_val[i];
         end else if (!dir_ff[i]) begin
            data_view[i] = pin_lvl[i];
         end else begin
            data_view[i] = pin_data_latch_ff[i];
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      nxt_rdata = GPEI_RDATA_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            GPEI_OFS_DATA:  nxt_rdata = data_view;
            GPEI_OFS_DIR:   nxt_rdata = dir_ff;
            GPEI_OFS_OPT:   nxt_rdata = opt_ff;
            GPEI_OFS_SENS:  nxt_rdata = {4'h0, ext_irq_sensitivity_ctrl_ff};
            GPEI_OFS_LEVEL: nxt_rdata = pin_lvl;
            default:        nxt_rdata = GPEI_RDATA_ZERO;
         endcase
      end
   end

   // Read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= GPEI_RDATA_ZERO;
      end else begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = reg_rdata_ff;

   //---------------------------------------------------------------------------
   // Pad control
   //---------------------------------------------------------------------------
   // Per-pin drive, enable and pull-up from kind, direction, option, peripheral
   always_comb begin
      nxt_out    = '0;
      nxt_oe_n   = '1;
      nxt_pullup = '0;
      for (int i = 0; i < GPEI_NPIN; i++) begin
         case (GPEI_PIN_KIND[i])
            GPEI_KIND_CAN_TX: begin
               if (alt_out_en[i]) begin
                  nxt_out[i]  = alt_out_val[i];
                  nxt_oe_n[i] = 1'b0;
               end else begin
                  nxt_pullup[i] = 1'b1;
               end
            end
            GPEI_KIND_TOD: begin
               // Low side only, so a one is never driven
               if (alt_out_en[i]) begin
                  nxt_oe_n[i] = alt_out_val[i];
               end else if (dir_ff[i]) begin
                  nxt_oe_n[i] = pin_data_latch_ff[i];
               end
            end
            default: begin
               if (alt_out_en[i]) begin
                  // Peripheral wins over direction and option
                  nxt_out[i]  = alt_out_val[i] & ~alt_out_od[i];
                  nxt_oe_n[i] = alt_out_od[i] & alt_out_val[i];
               end else if (dir_ff[i] && opt_ff[i]) begin
                  nxt_out[i]  = pin_data_latch_ff[i];
                  nxt_oe_n[i] = 1'b0;
               end else if (dir_ff[i]) begin
                  nxt_oe_n[i] = pin_data_latch_ff[i];
               end
               // Pull-up only on inputs, and never on floating irq pins
               if (!alt_out_en[i] && !dir_ff[i] && opt_ff[i] &&
                   (GPEI_PIN_KIND[i] != GPEI_KIND_IRQ_FL)) begin
                  nxt_pullup[i] = 1'b1;
               end
            end
         endcase
      end
   end

   // Peripheral input sees the latch when the pin is an output
   always_comb begin
      nxt_alt_in = pin_lvl;
      for (int i = 0; i < GPEI_NPIN; i++) begin
         if (dir_ff[i] && (GPEI_PIN_KIND[i] != GPEI_KIND_CAN_TX)) begin
            nxt_alt_in[i] = pin_data_latch_ff[i];
         end
      end
   end

   // Pad outputs registered; state is held through wait and halt
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_ff    <= '0;
         pin_oe_n_ff   <= '1;
         pin_pullup_ff <= '0;
      end else begin
         pin_out_ff    <= nxt_out;
         pin_oe_n_ff   <= nxt_oe_n;
         pin_pullup_ff <= nxt_pullup;
      end
   end

   // Peripheral input view registered
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alt_in_ff <= '0;
      end else begin
         alt_in_ff <= nxt_alt_in;
      end
   end

   assign pin_out       = pin_out_ff;
   assign pin_oe_n      = pin_oe_n_ff;
   assign pin_pullup_en = pin_pullup_ff;
   assign alt_in_val    = alt_in_ff;

   //---------------------------------------------------------------------------
   // External interrupt
   //---------------------------------------------------------------------------
   // Interrupt input selected by direction 0, option 1 on capable pins
   always_comb begin
      for (int i = 0; i < GPEI_NPIN; i++) begin
         irq_en[i] = kind_has_irq(GPEI_PIN_KIND[i]) && !dir_ff[i] && opt_ff[i];
      end
   end

   // Qualify every enabled pin first, then OR within its group
   always_comb begin
      for (int g = 0; g < GPEI_NGRP; g++) begin
         grp_evt[g]  = 1'b0;
         grp_wake[g] = 1'b0;
         for (int i = 0; i < GPEI_NPIN; i++) begin
            if (GPEI_GRP_PINS[g][i] && irq_en[i]) begin
               grp_evt[g] = grp_evt[g] | qualify(
                  ext_irq_sensitivity_ctrl_ff[g*GPEI_SENS_W +: GPEI_SENS_W],
                  pin_lvl[i], pin_rise[i], pin_fall[i]);
               // Raw pad against the frozen last level: works with no clock
               grp_wake[g] = grp_wake[g] | qualify(
                  ext_irq_sensitivity_ctrl_ff[g*GPEI_SENS_W +: GPEI_SENS_W],
                  pin_in[i], pin_in[i] & ~pin_prev[i],
                  ~pin_in[i] & pin_prev[i]);
            end
         end
      end
   end

   // Hidden request latch: set beats a vector fetch, sensitivity write clears
   always_comb begin
      for (int g = 0; g < GPEI_NGRP; g++) begin
         if (wr_sens) begin
            nxt_pend[g] = 1'b0;
         end else if (grp_evt[g]) begin
            nxt_pend[g] = 1'b1;
         end else if (vector_fetch[g]) begin
            nxt_pend[g] = 1'b0;
         end else begin
            nxt_pend[g] = pend_ff[g];
         end
      end
   end

   // Latch has no register address, so software cannot see it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // CPU mask hides requests without losing them
   assign ext_irq_req = pend_ff & {GPEI_NGRP{~cpu_irq_mask}};

   // Wake also from a held request, in case the clock stopped after it set
   assign ext_wake    = (|grp_wake) | (|pend_ff);

endmodule // gpei_port

// >>> gpei_pkg.sv
//------------------------------------------------------------------------------
// Port constants and pin input synchroniser
//------------------------------------------------------------------------------
// Functional notes
// - An input-with-interrupt pin raises an external interrupt request on a qualifying event.
// - Per group, qualify each enabled pin by its sensitivity, then OR into one request.
// - Requests sit in a software-invisible latch cleared by the matching vector fetch.
// - Writing the sensitivity register clears that register's pending request latches.
// - Output mode: data latch value drives the pin; reads return the latch.
// - Push-pull drives 0 low, 1 high; open-drain drives 0 low, releases 1.
// - A peripheral using a pin overrides direction and option programming.
// - Peripheral output forces output mode, push-pull or open-drain as the peripheral says.
// - Input pin with alternate output enabled: data reads return the alternate output.
// - Output pin with alternate input enabled: peripheral sees the data latch.
// - Wait and halt keep port state; external events wake, even without clock.
// - Interrupt only with interrupt configuration selected and CPU mask inactive.
// - Standard pins: 00 floating, 01 pull-up, 10 open-drain, 11 push-pull.
// - Interrupt pins: 01 is interrupt input, pulled up or floating per pin.
// - True open-drain pins: no option; 0 floating input, 1 low-only output.
// - CAN transmit pin: pull-up input only, push-pull when its alternate output runs.
// - Direction cleared: pin is input and data reads return the pin level.
// - Input mode data writes update the latch only, ready for output mode.
// - Bit n of direction, option and data latch serves pin n.
package gpei_pkg;
   localparam int          GPEI_NPIN          = 8;
   localparam int          GPEI_NGRP          = 2;
   localparam int          GPEI_AW            = 8;
   localparam int          GPEI_DW            = 8;
   // Register offsets
   localparam logic [7:0]  GPEI_OFS_DATA      = 8'h00;
   localparam logic [7:0]  GPEI_OFS_DIR       = 8'h01;
   localparam logic [7:0]  GPEI_OFS_OPT       = 8'h02;
   localparam logic [7:0]  GPEI_OFS_SENS      = 8'h03;
   localparam logic [7:0]  GPEI_OFS_LEVEL     = 8'h04;
   // Reset values
   localparam logic [7:0]  GPEI_RST_DATA      = 8'h00;
   localparam logic [7:0]  GPEI_RST_DIR       = 8'h00;
   localparam logic [7:0]  GPEI_RST_OPT       = 8'h00;
   localparam logic [3:0]  GPEI_RST_SENS      = 4'h0;
   localparam logic [7:0]  GPEI_RST_SYNC      = 8'h00;
   localparam logic [7:0]  GPEI_RDATA_ZERO    = 8'h00;
   // Sensitivity field: two bits per group, group g at bits 2g+1:2g
   localparam int          GPEI_SENS_W        = 2;
   localparam logic [1:0]  GPEI_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0]  GPEI_SENS_RISE     = 2'h1;
   localparam logic [1:0]  GPEI_SENS_FALL     = 2'h2;
   localparam logic [1:0]  GPEI_SENS_BOTH     = 2'h3;
   // Pin kinds
   localparam logic [2:0]  GPEI_KIND_STD      = 3'h0;
   localparam logic [2:0]  GPEI_KIND_IRQ_PU   = 3'h1;
   localparam logic [2:0]  GPEI_KIND_IRQ_FL   = 3'h2;
   localparam logic [2:0]  GPEI_KIND_TOD      = 3'h3;
   localparam logic [2:0]  GPEI_KIND_CAN_TX   = 3'h4;
   // Pin 0..7 kinds of this port instance
   localparam logic [2:0]  GPEI_PIN_KIND [GPEI_NPIN] = '{
      GPEI_KIND_IRQ_PU, GPEI_KIND_IRQ_PU, GPEI_KIND_IRQ_PU, GPEI_KIND_IRQ_FL,
      GPEI_KIND_STD, GPEI_KIND_CAN_TX, GPEI_KIND_TOD, GPEI_KIND_TOD};
   // Pins belonging to each interrupt vector group
   localparam logic [7:0]  GPEI_GRP_PINS [GPEI_NGRP] = '{8'h03, 8'h0C};
endpackage

`timescale 1ns/1ps

//------------------------------------------------------------------------------
// Two-stage synchroniser with edge detect
//------------------------------------------------------------------------------
module gpei_pin_sync
   import gpei_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic [GPEI_NPIN-1:0] pin_raw,
   output logic      [GPEI_NPIN-1:0] pin_lvl,
   output logic      [GPEI_NPIN-1:0] pin_prev,
   output logic      [GPEI_NPIN-1:0] pin_rise,
   output logic      [GPEI_NPIN-1:0] pin_fall
);
   logic [GPEI_NPIN-1:0] meta_ff;
   logic [GPEI_NPIN-1:0] sync_ff;
   logic [GPEI_NPIN-1:0] prev_ff;

   // First stage is read only by the second stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= GPEI_RST_SYNC;
         sync_ff <= GPEI_RST_SYNC;
      end else begin
         meta_ff <= pin_raw;
         sync_ff <= meta_ff;
      end
   end

   // Previous level; frozen while the clock stops, so halt wake compares to it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= GPEI_RST_SYNC;
      end else begin
         prev_ff <= sync_ff;
      end
   end

   assign pin_lvl  = sync_ff;
   assign pin_prev = prev_ff;
   assign pin_rise = sync_ff & ~prev_ff;
   assign pin_fall = ~sync_ff & prev_ff;
endmodule // gpei_pin_sync

// >>> gpei_port_chk.sv
`timescale 1ns/1ps

//------------------------------------------------------------------------------
// Port-level checker for the I/O port
//------------------------------------------------------------------------------
module gpei_port_chk
   import gpei_pkg::*;
(
   input wire logic                 clk_sys,
   input wire logic                 rst_n,
   input wire logic [GPEI_AW-1:0]   reg_addr,
   input wire logic                 reg_wr,
   input wire logic [GPEI_NPIN-1:0] pin_out,
   input wire logic [GPEI_NPIN-1:0] pin_oe_n,
   input wire logic [GPEI_NPIN-1:0] pin_pullup_en,
   input wire logic [GPEI_NPIN-1:0] alt_out_en,
   input wire logic [GPEI_NPIN-1:0] alt_out_val,
   input wire logic [GPEI_NPIN-1:0] alt_out_od,
   input wire logic                 cpu_irq_mask,
   input wire logic [GPEI_NGRP-1:0] ext_irq_req,
   input wire logic                 ext_wake
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Sensitivity write drops every pending request by the next edge
   chk_sens_clear: assert property (
      reg_wr && reg_addr == GPEI_OFS_SENS |=> ext_irq_req == 2'h0)
      else $error("request survived a sensitivity write");
   // Mask hides requests; the latch itself is not watched here
   chk_mask_hides: assert property (
      cpu_irq_mask |-> ext_irq_req == 2'h0)
      else $error("request shown while masked");
   // Any visible request must also wake a stopped core
   chk_wake_pend: assert property (
      ext_irq_req != 2'h0 |-> ext_wake)
      else $error("pending request without wake");
   // True open-drain pads never push high
   chk_tod_lowonly: assert property (
      pin_out[7:6] == 2'h0)
      else $error("open-drain pad driven high");
   // Transmit pad idles as pull-up input; $past(rst_n) skips the reset edge
   chk_can_pullup: assert property (
      $past(rst_n) && !$past(alt_out_en[5]) |-> pin_oe_n[5] && pin_pullup_en[5])
      else $error("transmit pad not a pull-up input");
   chk_can_drive: assert property (
      $past(rst_n) && $past(alt_out_en[5]) |-> !pin_oe_n[5] && pin_out[5] == $past(alt_out_val[5]))
      else $error("transmit pad not push-pull from peripheral");
   // Peripheral override on a standard pin, both drive styles
   chk_alt_pp: assert property (
      $past(rst_n) && $past(alt_out_en[4] && !alt_out_od[4])
         |-> !pin_oe_n[4] && pin_out[4] == $past(alt_out_val[4]))
      else $error("peripheral push-pull not applied");
   chk_alt_od: assert property (
      $past(rst_n) && $past(alt_out_en[4] && alt_out_od[4])
         |-> !pin_out[4] && pin_oe_n[4] == $past(alt_out_val[4]))
      else $error("peripheral open-drain not applied");
endmodule // gpei_port_chk

bind gpei_port gpei_port_chk gpei_port_chk_inst (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
   .alt_out_en(alt_out_en), .alt_out_val(alt_out_val), .alt_out_od(alt_out_od),
   .cpu_irq_mask(cpu_irq_mask), .ext_irq_req(ext_irq_req), .ext_wake(ext_wake)
);

// >>> gpei_board.sv
`timescale 1ns/1ps

//------------------------------------------------------------------------------
// Board circuitry on the port pads
//------------------------------------------------------------------------------
module gpei_board
   import gpei_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic [GPEI_NPIN-1:0] pin_out,
   input  wire logic [GPEI_NPIN-1:0] pin_oe_n,
   input  wire logic [GPEI_NPIN-1:0] pin_pullup_en,
   input  wire logic [GPEI_NPIN-1:0] ext_en,
   input  wire logic [GPEI_NPIN-1:0] ext_val,
   output logic      [GPEI_NPIN-1:0] pin_in
);
   logic [GPEI_NPIN-1:0] flt_ff = 8'h55;

   // Undriven pads wander so a stale value is never read as valid
   always_ff @(posedge clk_sys) begin
      flt_ff <= ~flt_ff;
   end

   // Chip drive wins, then the external source, then pull-up, else noise
   always_comb begin
      for (int i = 0; i < GPEI_NPIN; i++) begin
         if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (pin_pullup_en[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = flt_ff[i]; // Released open-drain one floats
      end
   end
endmodule // gpei_board

// >>> tb_gpio_port_ext_interrupt.sv
`timescale 1ns/1ps

module tb_gpio_port_ext_interrupt
   import gpei_pkg::*;
;
   typedef struct {string nm; logic [7:0] v;} gpei_exp_t;
   logic       clk_sys, rst_n, reg_wr, reg_rd, cpu_irq_mask, ext_wake;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, pin_pullup_en;
   logic [7:0] alt_out_en, alt_out_val, alt_out_od, alt_in_val, ext_en, ext_val, d, e;
   logic [1:0] vector_fetch, ext_irq_req;
   logic       rd_pend = 1'b0;
   logic [31:0] seed;
   int         errors, n_compared;
   gpei_exp_t  exp_q[$];

   gpei_port gpei_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .alt_out_en(alt_out_en), .alt_out_val(alt_out_val),
      .alt_out_od(alt_out_od), .alt_in_val(alt_in_val), .cpu_irq_mask(cpu_irq_mask),
      .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req), .ext_wake(ext_wake));
   gpei_board gpei_board_inst (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   //---------------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------------
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task check(string nm, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task wr(logic [7:0] a, logic [7:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read notes its expectation; the monitor compares it one cycle later
   task rd(logic [7:0] a, logic [7:0] v, string nm);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back('{nm, v});
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   task irq_is(string nm, logic [1:0] v);
      check(nm, {6'h00, ext_irq_req}, {6'h00, v});
   endtask

   task fetch(logic [1:0] g);
      @(posedge clk_sys);
      vector_fetch <= g;
      @(posedge clk_sys);
      vector_fetch <= 2'h0;
   endtask

   task end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   //---------------------------------------------------------------------------
   // Clock, monitor, watchdog
   //---------------------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge clk_sys) begin
      gpei_exp_t x;
      if (rd_pend) begin
         x = exp_q.pop_front();
         check(x.nm, reg_rdata, x.v);
      end
      rd_pend <= reg_rd && rst_n;
   end

   initial begin
      cyc(20000);
      errors++;
      end_of_test();
   end

   //---------------------------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------------------------
   initial begin
      seed = 32'd7715;
      {rst_n, reg_wr, reg_rd, cpu_irq_mask} = 4'h0;
      {reg_addr, reg_wdata, alt_out_en, alt_out_val, alt_out_od} = '0;
      vector_fetch = 2'h0;
      ext_en = 8'hFF;
      ext_val = xs();
      e = ext_val;
      cyc(16);
      rst_n <= 1'b1;
      // Reset state: all floating inputs, transmit pad pulled up
      cyc(4);
      check("oe_rst", pin_oe_n, 8'hFF);
      check("pu_rst", pin_pullup_en, 8'h20);
      rd(GPEI_OFS_DATA, e, "data_in");
      rd(GPEI_OFS_DIR, GPEI_RST_DIR, "dir_rst");
      rd(GPEI_OFS_OPT, GPEI_RST_OPT, "opt_rst");
      rd(GPEI_OFS_SENS, 8'h00, "sens_rst");
      rd(8'h10, 8'h00, "unmapped");
      wr(GPEI_OFS_LEVEL, 8'hA5);
      rd(GPEI_OFS_LEVEL, e, "level_ro");
      d = xs();
      wr(GPEI_OFS_DIR, d);
      rd(GPEI_OFS_DIR, d, "dir_rw");
      d = xs();
      wr(GPEI_OFS_OPT, d);
      rd(GPEI_OFS_OPT, d, "opt_rw");
      $display("test registers done");
      // Latch written as input first, then pins turned to outputs
      wr(GPEI_OFS_DIR, 8'h00);
      wr(GPEI_OFS_OPT, 8'h1F);
      ext_en <= 8'h60;
      d = xs();
      wr(GPEI_OFS_DATA, d);
      cyc(2);
      check("oe_in", pin_oe_n, 8'hFF);
      check("pu_in", pin_pullup_en, 8'h37);
      wr(GPEI_OFS_DIR, 8'h9F);
      cyc(4);
      check("pp_lvl", pin_in & 8'h1F, d & 8'h1F);
      check("oe_pp", pin_oe_n, {d[7], 7'h60});
      rd(GPEI_OFS_DATA, {d[7], e[6:5], d[4:0]}, "data_out");
      wr(GPEI_OFS_OPT, 8'h00);
      cyc(2);
      check("oe_od", pin_oe_n, {d[7], 2'h3, d[4:0]});
      check("out_od", pin_out, 8'h00);
      $display("test outputs done");
      // Peripheral takes pins 4 and 5
      wr(GPEI_OFS_DIR, 8'h10);
      ext_en <= 8'hCF;
      alt_out_en <= 8'h30;
      alt_out_val <= 8'h30;
      cyc(4);
      check("alt_in", alt_in_val & 8'h10, d & 8'h10);
      check("alt_pad", pin_in & 8'h30, 8'h30);
      wr(GPEI_OFS_DIR, 8'h00); // Floating inputs under the peripheral
      cyc(4);
      rd(GPEI_OFS_DATA, {e[7:6], 2'h3, e[3:0]}, "data_alt");
      repeat (6) begin
         @(posedge clk_sys);
         alt_out_val <= xs();
         alt_out_od <= xs();
      end
      alt_out_en <= 8'h00; // Off before interrupt use
      $display("test alternate done");
      // Every sensitivity code on group 0, pin 0
      ext_en <= 8'hFF;
      ext_val <= 8'hFF;
      wr(GPEI_OFS_OPT, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wr(GPEI_OFS_SENS, 8'(c));
         cyc(2);
         irq_is("irq_idle", 2'h0);
         ext_val[0] <= 1'b0;
         cyc(6);
         irq_is("irq_fall", {1'b0, c != 1});
         fetch(2'h1);
         cyc(2);
         irq_is("irq_fetch", {1'b0, c == 0});
         ext_val[0] <= 1'b1;
         cyc(6);
         irq_is("irq_rise", {1'b0, c != 2});
         wr(GPEI_OFS_SENS, 8'(c));
         cyc(1);
         irq_is("irq_clear", 2'h0);
      end
      // Group 1: masked, unmasked, fetched, second pin ORed in
      wr(GPEI_OFS_OPT, 8'h0C);
      wr(GPEI_OFS_SENS, 8'h08);
      cpu_irq_mask <= 1'b1;
      ext_val[2] <= 1'b0;
      cyc(6);
      irq_is("irq_mask", 2'h0);
      check("wake_mask", {7'h00, ext_wake}, 8'h01);
      cpu_irq_mask <= 1'b0;
      cyc(1);
      irq_is("irq_unmask", 2'h2);
      fetch(2'h2);
      cyc(2);
      irq_is("irq_fetch1", 2'h0);
      ext_val[3] <= 1'b0;
      cyc(6);
      irq_is("irq_or", 2'h2);
      $display("test interrupts done");
      cyc(2);
      end_of_test();
   end
endmodule // tb_gpio_port_ext_interrupt
